// File: rtl/range_match_map.svh
`ifndef RANGE_MATCH_MAP_SVH
`define RANGE_MATCH_MAP_SVH

// ----------------------------------------
// Register address and reset value
// ----------------------------------------
`define RANGE_CTRL_MSR_ADDR    32'hC0000085
`define RANGE_CTRL_RESET       64'h0000000000000000

// ----------------------------------------
// Field positions inside one 32-bit half
// ----------------------------------------
`define RANGE_HALF_WIDTH       32
`define RANGE_UNCACHED_BIT     0
`define RANGE_COMBINE_BIT      1
`define RANGE_MASK_LSB         2
`define RANGE_MASK_MSB         16
`define RANGE_BASE_LSB         17
`define RANGE_BASE_MSB         31
`define RANGE_ADDR_LSB         17
`define RANGE_ADDR_MSB         31

// ----------------------------------------
// Merge buffer
// ----------------------------------------
`define MERGE_BYTES            8

`endif

// File: rtl/range_match_pkg.sv
package range_match_pkg;

	typedef enum logic [1:0] {
		MEM_CACHEABLE_T   = 2'h0,
		MEM_COMBINING_T   = 2'h1,
		MEM_UNCACHEABLE_T = 2'h3
	} mem_type_t;

	typedef logic [14:0] range_field_t;

endpackage

// File: rtl/memory_type_range_match.sv
`timescale 1ns/1ps
`include "range_match_map.svh"

// What this block does
// [RL1] Two independent ranges exist, each typed uncacheable or write-combining.
// [RL2] An uncacheable hit reads and writes memory with no line or write allocation.
// [RL3] A write-combining hit reads without allocation and its writes may merge.
// [RL4] Both ranges live in one 64-bit register at a fixed model-specific address.
// [RL5] Reset clears the whole register so neither range has any effect.
// [RL6] The low half defines range 0 and the high half range 1.
// [RL7] Each base field holds address bits 31..17, lower bits implied zero.
// [RL8] Each mask field holds 15 upper mask bits that set the range size.
// [RL9] An address hits when mask AND base equals mask AND address.
// [RL10] Uncached set wins; combine alone means write-combining; both clear no effect.
// [RL11] Combine and uncached sit at bits 1 and 0, and at bits 33 and 32.
// [RL12] Software keeps ranges at least 128 Kbytes, size aligned, masks contiguous.
// [RL13] Masks run from all ones (128 Kbytes) to all zeros (4 Gbytes).
// [RL14] Write-combining data goes to an 8-byte merge buffer.
// [RL15] The compare uses address bits 31 down to 17.
// [RL16] Overlapping hits are uncacheable if either is, else write-combining if either is.
module memory_type_range_match
	import range_match_pkg::*;
#(
	parameter int MERGE_BYTES = `MERGE_BYTES
) (
	// Clock and reset
	input  wire logic              clock_in,
	input  wire logic              sys_rst_in,
	// Model-specific register port
	input  wire logic              msr_wr_in,
	input  wire logic              msr_rd_in,
	input  wire logic [31:0]       msr_addr_in,
	input  wire logic [63:0]       msr_wdata_in,
	output logic      [63:0]       msr_rdata_out,
	output logic                   msr_hit_out,
	// Address to classify
	input  wire logic              addr_valid_in,
	input  wire logic [31:0]       phys_addr_in,
	input  wire logic              addr_write_in,
	// Classification
	output logic                   class_valid_out,
	output range_match_pkg::mem_type_t mem_type_out,
	output logic                   no_allocate_out,
	output logic                   merge_write_out,
	output logic [1:0]             range_hit_out
);
	import range_match_pkg::*;

	// Only the 8-byte merge path exists in the classifier
	if (MERGE_BYTES != 8) begin : g_merge_width_check
		$error("merge buffer must be 8 bytes wide");
	end

	// ----------------------------------------
	// Range control register
	// ----------------------------------------
	logic [63:0] ctrl_reg;
	logic [63:0] ctrl_next;
	logic [63:0] rdata_reg;
	logic [63:0] rdata_next;
	logic        hit_reg;
	logic        hit_next;
	logic        addr_match;

	assign addr_match = (msr_addr_in == `RANGE_CTRL_MSR_ADDR); // [RL4]

	always_comb begin
		ctrl_next  = ctrl_reg;
		rdata_next = 64'h0000000000000000;
		hit_next   = 1'b0;
		if (msr_wr_in && addr_match) begin
			ctrl_next = msr_wdata_in; // [RL4]
			hit_next  = 1'b1;
		end
		if (msr_rd_in && addr_match) begin
			rdata_next = ctrl_reg;
			hit_next   = 1'b1;
		end
	end

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			ctrl_reg  <= `RANGE_CTRL_RESET; // [RL5]
			rdata_reg <= 64'h0000000000000000;
			hit_reg   <= 1'b0;
		end else begin
			ctrl_reg  <= ctrl_next;
			rdata_reg <= rdata_next;
			hit_reg   <= hit_next;
		end
	end

	assign msr_rdata_out = rdata_reg;
	assign msr_hit_out   = hit_reg;

	// ----------------------------------------
	// Range decode
	// ----------------------------------------
	function automatic logic range_hits(input logic [31:0] half, input logic [31:0] addr);
		range_field_t base;
		range_field_t mask;
		range_field_t page;
		base = half[`RANGE_BASE_MSB:`RANGE_BASE_LSB]; // [RL7]
		mask = half[`RANGE_MASK_MSB:`RANGE_MASK_LSB]; // [RL8]
		page = addr[`RANGE_ADDR_MSB:`RANGE_ADDR_LSB]; // [RL15]
		return (mask & base) == (mask & page); // [RL9]
	endfunction

	function automatic mem_type_t range_type(input logic [31:0] half);
		if (half[`RANGE_UNCACHED_BIT]) // [RL10]
			return MEM_UNCACHEABLE_T;
		else if (half[`RANGE_COMBINE_BIT])
			return MEM_COMBINING_T;
		else
			return MEM_CACHEABLE_T;
	endfunction

	logic [31:0] range0_descriptor;
	logic [31:0] range1_descriptor;
	assign range0_descriptor = ctrl_reg[`RANGE_HALF_WIDTH-1:0];                    // [RL6]
	assign range1_descriptor = ctrl_reg[2*`RANGE_HALF_WIDTH-1:`RANGE_HALF_WIDTH]; // [RL6] [RL11]

	// ----------------------------------------
	// Classification, one cycle after request
	// ----------------------------------------
	mem_type_t   type_reg;
	mem_type_t   type_next;
	logic        valid_reg;
	logic        valid_next;
	logic        noalloc_reg;
	logic        noalloc_next;
	logic        merge_reg;
	logic        merge_next;
	logic [1:0]  hits_reg;
	logic [1:0]  hits_next;

	always_comb begin
		mem_type_t t0;
		mem_type_t t1;
		t0 = MEM_CACHEABLE_T;
		t1 = MEM_CACHEABLE_T;
		hits_next = {range_hits(range1_descriptor, phys_addr_in),
		             range_hits(range0_descriptor, phys_addr_in)}; // [RL1]
		if (hits_next[0])
			t0 = range_type(range0_descriptor);
		if (hits_next[1])
			t1 = range_type(range1_descriptor);
		// Uncacheable dominates over write-combining on overlap
		if (t0 == MEM_UNCACHEABLE_T || t1 == MEM_UNCACHEABLE_T) // [RL16]
			type_next = MEM_UNCACHEABLE_T;
		else if (t0 == MEM_COMBINING_T || t1 == MEM_COMBINING_T)
			type_next = MEM_COMBINING_T;
		else
			type_next = MEM_CACHEABLE_T;
		valid_next   = addr_valid_in;
		noalloc_next = addr_valid_in && (type_next != MEM_CACHEABLE_T); // [RL2] [RL3]
		// Only writes into a combining range go to the 8-byte merge buffer
		merge_next   = addr_valid_in && addr_write_in // [RL3] [RL14]
			&& (type_next == MEM_COMBINING_T);
		if (!addr_valid_in) begin
			type_next = MEM_CACHEABLE_T;
			hits_next = 2'h0;
		end
	end

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			type_reg    <= MEM_CACHEABLE_T;
			valid_reg   <= 1'b0;
			noalloc_reg <= 1'b0;
			merge_reg   <= 1'b0;
			hits_reg    <= 2'h0;
		end else begin
			type_reg    <= type_next;
			valid_reg   <= valid_next;
			noalloc_reg <= noalloc_next;
			merge_reg   <= merge_next;
			hits_reg    <= hits_next;
		end
	end

	assign class_valid_out = valid_reg;
	assign mem_type_out    = type_reg;
	assign no_allocate_out = noalloc_reg;
	assign merge_write_out = merge_reg;
	assign range_hit_out   = hits_reg;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_reset_clears_ctrl: assert property (@(posedge clock_in) // [RL5]
		sys_rst_in |=> ctrl_reg == 64'h0000000000000000)
		else $error("range register not cleared by reset");

	a_write_stores_ctrl: assert property (@(posedge clock_in) disable iff (sys_rst_in) // [RL4]
		(msr_wr_in && msr_addr_in == 32'hC0000085) |=> ctrl_reg == $past(msr_wdata_in))
		else $error("register write lost");

	a_other_addr_ignored: assert property (@(posedge clock_in) disable iff (sys_rst_in) // [RL4]
		(msr_addr_in != 32'hC0000085) |=> $stable(ctrl_reg))
		else $error("register changed by other address");

	a_uncached_wins_type: assert property (@(posedge clock_in) disable iff (sys_rst_in) // [RL10]
		(addr_valid_in && ((hits_next[0] && ctrl_reg[0]) || (hits_next[1] && ctrl_reg[32])))
		|=> mem_type_out == MEM_UNCACHEABLE_T && no_allocate_out && !merge_write_out)
		else $error("uncached range not classed uncacheable");

	a_merge_on_combine: assert property (@(posedge clock_in) disable iff (sys_rst_in) // [RL3]
		(addr_valid_in && addr_write_in
		 && !((hits_next[0] && ctrl_reg[0]) || (hits_next[1] && ctrl_reg[32]))
		 && ((hits_next[0] && ctrl_reg[1]) || (hits_next[1] && ctrl_reg[33])))
		|=> merge_write_out && mem_type_out == MEM_COMBINING_T)
		else $error("combining write not merged");

	a_read_never_merges: assert property (@(posedge clock_in) disable iff (sys_rst_in) // [RL3]
		(addr_valid_in && !addr_write_in) |=> !merge_write_out)
		else $error("read sent to merge buffer");

	a_range0_match_eq: assert property (@(posedge clock_in) disable iff (sys_rst_in) // [RL9]
		addr_valid_in |=> range_hit_out[0] ==
		(($past(ctrl_reg[16:2]) & $past(ctrl_reg[31:17])) ==
		 ($past(ctrl_reg[16:2]) & $past(phys_addr_in[31:17]))))
		else $error("range 0 match wrong");

	a_range1_match_eq: assert property (@(posedge clock_in) disable iff (sys_rst_in) // [RL6]
		addr_valid_in |=> range_hit_out[1] ==
		(($past(ctrl_reg[48:34]) & $past(ctrl_reg[63:49])) ==
		 ($past(ctrl_reg[48:34]) & $past(phys_addr_in[31:17]))))
		else $error("range 1 match wrong");

	a_clear_no_effect: assert property (@(posedge clock_in) disable iff (sys_rst_in) // [RL10]
		(ctrl_reg[1:0] == 2'h0 && ctrl_reg[33:32] == 2'h0)
		|=> mem_type_out == MEM_CACHEABLE_T && !no_allocate_out)
		else $error("inactive ranges changed type");

endmodule

// File: dv/core_addr_model.sv
`timescale 1ns/1ps
// ----
// Address source
// ----
module core_addr_model (
	input  wire logic        clock_in,
	input  wire logic        go_in,
	input  wire logic [31:0] addr_in,
	input  wire logic        write_in,
	output logic             addr_valid_out,
	output logic [31:0]      phys_addr_out,
	output logic             addr_write_out
);
	initial begin
		addr_valid_out = 1'b0;
		phys_addr_out  = 32'h0;
		addr_write_out = 1'b0;
	end
	// Idle lines flip each cycle so a stale address never looks valid
	always @(posedge clock_in) begin
		addr_valid_out <= go_in;
		phys_addr_out  <= go_in ? addr_in : ~phys_addr_out;
		addr_write_out <= go_in ? write_in : ~addr_write_out;
	end
endmodule

// File: dv/memory_type_range_match_bench.sv
`timescale 1ns/1ps
`include "range_match_map.svh"
module memory_type_range_match_bench;
	import range_match_pkg::*;
	logic        clock_in = 1'b0, sys_rst_in = 1'b1;
	logic        msr_wr_in = 1'b0, msr_rd_in = 1'b0, go = 1'b0, wr = 1'b0;
	logic [31:0] msr_addr_in = 32'h0, ad = 32'h0, phys_addr_in;
	logic [63:0] msr_wdata_in = 64'h0, msr_rdata_out, shadow = 64'h0;
	logic        msr_hit_out, addr_valid_in, addr_write_in, class_valid_out;
	logic        no_allocate_out, merge_write_out;
	logic [1:0]  range_hit_out;
	mem_type_t   mem_type_out;
	int          errors = 0, n_compared = 0, cycles = 0;
	logic [31:0] pts [8] = '{32'h0100_0000, 32'h01FF_FFFF, 32'h0200_0000, 32'h00FF_FFFF,
		32'h4000_0000, 32'h407F_FFFF, 32'h4080_0000, 32'h3FFF_FFFF};

	core_addr_model PARTNER (.clock_in(clock_in), .go_in(go), .addr_in(ad), .write_in(wr),
		.addr_valid_out(addr_valid_in), .phys_addr_out(phys_addr_in),
		.addr_write_out(addr_write_in));
	memory_type_range_match DUT (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
		.msr_wr_in(msr_wr_in), .msr_rd_in(msr_rd_in), .msr_addr_in(msr_addr_in),
		.msr_wdata_in(msr_wdata_in), .msr_rdata_out(msr_rdata_out), .msr_hit_out(msr_hit_out),
		.addr_valid_in(addr_valid_in), .phys_addr_in(phys_addr_in),
		.addr_write_in(addr_write_in), .class_valid_out(class_valid_out),
		.mem_type_out(mem_type_out), .no_allocate_out(no_allocate_out),
		.merge_write_out(merge_write_out), .range_hit_out(range_hit_out));

	initial forever #25 clock_in = ~clock_in;

	// ----
	// Tasks
	// ----
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic test_done();
		if (errors == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic wr_reg(input logic [31:0] a, input logic [63:0] d);
		@(posedge clock_in);
		msr_wr_in    <= 1'b1;
		msr_addr_in  <= a;
		msr_wdata_in <= d;
		@(posedge clock_in);
		msr_wr_in <= 1'b0;
		#1 check(msr_hit_out, a == `RANGE_CTRL_MSR_ADDR);
		if (a == `RANGE_CTRL_MSR_ADDR) shadow = d;
	endtask

	task automatic rd_reg(input logic [31:0] a);
		@(posedge clock_in);
		msr_rd_in   <= 1'b1;
		msr_addr_in <= a;
		@(posedge clock_in);
		msr_rd_in <= 1'b0;
		#1 check(msr_hit_out, a == `RANGE_CTRL_MSR_ADDR);
		check(msr_rdata_out, (a == `RANGE_CTRL_MSR_ADDR) ? shadow : 64'h0);
	endtask

	// Expectation built from the shadow copy, never from the outputs
	task automatic classify(input logic [31:0] a, input logic w);
		logic [1:0] h;
		logic [1:0] t;
		h[0] = (shadow[16:2] & shadow[31:17]) == (shadow[16:2] & a[31:17]);
		h[1] = (shadow[48:34] & shadow[63:49]) == (shadow[48:34] & a[31:17]);
		t = |(h & {shadow[32], shadow[0]}) ? MEM_UNCACHEABLE_T :
			(|(h & {shadow[33], shadow[1]}) ? MEM_COMBINING_T : MEM_CACHEABLE_T);
		@(posedge clock_in);
		go <= 1'b1;
		ad <= a;
		wr <= w;
		@(posedge clock_in);
		go <= 1'b0;
		// Idle cycle: partner scrambles the address, outputs must stay quiet
		#1 check(class_valid_out, 1'b0);
		check(range_hit_out, 2'h0);
		check(mem_type_out, MEM_CACHEABLE_T);
		check(no_allocate_out, 1'b0);
		check(merge_write_out, 1'b0);
		@(posedge clock_in);
		#1 check(class_valid_out, 1'b1);
		check(range_hit_out, h);
		check(mem_type_out, t);
		check(no_allocate_out, t != MEM_CACHEABLE_T);
		check(merge_write_out, w && t == MEM_COMBINING_T);
	endtask

	always @(posedge clock_in) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			errors++;
			test_done();
		end
	end

	// ----
	// Sequence
	// ----
	initial begin
		repeat (5) @(posedge clock_in);
		sys_rst_in <= 1'b0;
		rd_reg(`RANGE_CTRL_MSR_ADDR);
		classify(32'h1234_5678, 1'b1);
		wr_reg(32'hC000_0084, 64'hFFFF_FFFF_FFFF_FFFF);
		rd_reg(32'hC000_0086);
		// 16 MB uncacheable at 16 MB, 8 MB combining at 1 GB
		wr_reg(`RANGE_CTRL_MSR_ADDR,
			{15'h2000, 15'h7FC0, 2'h2, 15'h0080, 15'h7F80, 2'h1});
		rd_reg(`RANGE_CTRL_MSR_ADDR);
		foreach (pts[i]) classify(pts[i], i[0]);
		// Whole-space ranges: every type pair, overlapping
		for (int k = 0; k < 16; k++) begin
			wr_reg(`RANGE_CTRL_MSR_ADDR, {30'h0, k[3:2], 30'h0, k[1:0]});
			classify(32'h8000_0000, k[3] ^ k[0]);
		end
		@(posedge clock_in);
		sys_rst_in <= 1'b1;
		@(posedge clock_in);
		sys_rst_in <= 1'b0;
		shadow = 64'h0;
		rd_reg(`RANGE_CTRL_MSR_ADDR);
		test_done();
	end
endmodule
